// ---- src/mpu_core.sv ----
// Memory region protection: APB register file and access checker.
// Assumes one checked access per cycle from the core, same clock.
// Notes on behaviour
// - Up to eight regions, own base and attributes
// - Region size power of two, 32B to 4GB
// - Fetch from non-executable region faults
// - Data permissions separate for privileged and user
// - Eight sub-regions, each may be disabled
// - Violation with protection on raises fault
// - Region disable keeps base; the same RASR write reloads the attributes
// - Privileged-default option: privileged miss uses default
// - No default option: miss on enabled checker faults
// - Handlers bypass checks unless option set
// - Protection off: default map, never faults
// - Readable total count of supported regions
// - Region readback matches programming format
// - Sub-region holes only for 256 bytes up
// - Six privileged/user permission combinations
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module mpu_core
	import mpu_pkg::*;
#(
	parameter int NUM_REGIONS = NUM_REGIONS_DEF
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic acc_valid,
	input wire logic [31:0] acc_addr,
	input wire logic acc_write,
	input wire logic acc_fetch,
	input wire logic acc_priv,
	input wire logic acc_in_handler,
	output logic chk_done,
	output logic mm_fault
);
	localparam int IW = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;

	logic pready_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic done_ff;
	logic fault_ff;
	logic [2:0] ctrl_ff;
	logic [7:0] rnr_ff;
	logic [31:0] faddr_ff;
	logic [26:0] rbase_ff [NUM_REGIONS];
	logic [4:0] rsize_ff [NUM_REGIONS];
	logic [7:0] rsrd_ff [NUM_REGIONS];
	logic [2:0] rap_ff [NUM_REGIONS];
	logic rxn_ff [NUM_REGIONS];
	logic ren_ff [NUM_REGIONS];
	logic [NUM_REGIONS-1:0] hit;
	logic [IW-1:0] sel;
	logic apb_req;
	logic wr;
	logic mapped;
	logic [31:0] nxt_prdata;
	logic [4:0] nxt_size;
	logic any_hit;
	logic [IW-1:0] win;
	logic pr;
	logic pw;
	logic ur;
	logic uw;
	logic allowed;
	logic check_on;
	logic viol;

	assign pready = pready_ff;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;
	assign chk_done = done_ff;
	assign mm_fault = fault_ff;
	assign sel = rnr_ff[IW-1:0];

	// APB access phase: one wait state, then pready
	assign apb_req = psel && penable && !pready_ff;
	assign wr = psel && penable && pready_ff && pwrite;
	assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_TYPE) ||
		(paddr == OFF_RNR) || (paddr == OFF_RBAR) ||
		(paddr == OFF_RASR) || (paddr == OFF_FADDR);

	always_comb begin
		nxt_prdata = 32'h00000000;
		unique case (paddr)
			OFF_CTRL: nxt_prdata = {29'h0, ctrl_ff};
			OFF_TYPE: nxt_prdata = 32'(NUM_REGIONS);
			OFF_RNR: nxt_prdata = {24'h0, rnr_ff};
			OFF_RBAR: nxt_prdata = {rbase_ff[sel], 5'h00};
			OFF_RASR: begin
				nxt_prdata[RASR_EN_BIT] = ren_ff[sel];
				nxt_prdata[RASR_SIZE_LSB +: 5] = rsize_ff[sel];
				nxt_prdata[RASR_SRD_LSB +: 8] = rsrd_ff[sel];
				nxt_prdata[RASR_AP_LSB +: 3] = rap_ff[sel];
				nxt_prdata[RASR_XN_BIT] = rxn_ff[sel];
			end
			OFF_FADDR: nxt_prdata = faddr_ff;
			default: nxt_prdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= apb_req;
			prdata_ff <= (apb_req && !pwrite) ? nxt_prdata : 32'h00000000;
			pslverr_ff <= apb_req && !mapped;
		end
	end

	// Global control and region select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr && paddr == OFF_CTRL) begin
			ctrl_ff <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rnr_ff <= RNR_RST;
		end else if (wr && paddr == OFF_RNR &&
				pwdata[7:0] < 8'(NUM_REGIONS)) begin
			rnr_ff <= pwdata[7:0];
		end
	end

	// Size below 32 bytes is raised to the minimum
	assign nxt_size = (pwdata[RASR_SIZE_LSB +: 5] < SIZE_MIN) ?
		SIZE_MIN : pwdata[RASR_SIZE_LSB +: 5];

	// Per-region storage and matcher
	for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_rgn
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rbase_ff[g] <= 27'h0000000;
				rsize_ff[g] <= SIZE_MIN;
				rsrd_ff[g] <= 8'h00;
				rap_ff[g] <= AP_NO_NO;
				rxn_ff[g] <= 1'b0;
				ren_ff[g] <= 1'b0;
			end else if (wr && sel == IW'(g)) begin
				if (paddr == OFF_RBAR) begin
					rbase_ff[g] <= pwdata[31:BASE_LSB];
				end
				if (paddr == OFF_RASR) begin
					// A RASR write reloads every field along with the enable bit
					ren_ff[g] <= pwdata[RASR_EN_BIT];
					rsize_ff[g] <= nxt_size;
					rsrd_ff[g] <= pwdata[RASR_SRD_LSB +: 8];
					rap_ff[g] <= pwdata[RASR_AP_LSB +: 3];
					rxn_ff[g] <= pwdata[RASR_XN_BIT];
				end
			end
		end

		region_match u_match (
			.addr(acc_addr),
			.base(rbase_ff[g]),
			.size(rsize_ff[g]),
			.srd(rsrd_ff[g]),
			.en(ren_ff[g]),
			.hit(hit[g])
		);
	end

	// Highest numbered hit wins on overlap
	always_comb begin
		any_hit = 1'b0;
		win = '0;
		for (int i = 0; i < NUM_REGIONS; i++) begin
			if (hit[i]) begin
				any_hit = 1'b1;
				win = IW'(i);
			end
		end
	end

	// Permission decode; unused codes grant nothing
	always_comb begin
		pr = 1'b0;
		pw = 1'b0;
		ur = 1'b0;
		uw = 1'b0;
		unique case (rap_ff[win])
			AP_NO_NO: pr = 1'b0;
			AP_RW_NO: begin
				pr = 1'b1;
				pw = 1'b1;
			end
			AP_RW_RO: begin
				pr = 1'b1;
				pw = 1'b1;
				ur = 1'b1;
			end
			AP_RW_RW: begin
				pr = 1'b1;
				pw = 1'b1;
				ur = 1'b1;
				uw = 1'b1;
			end
			AP_RO_NO: pr = 1'b1;
			AP_RO_RO: begin
				pr = 1'b1;
				ur = 1'b1;
			end
			default: pr = 1'b0;
		endcase
	end

	assign allowed = acc_priv ? (acc_write ? pw : pr) :
		(acc_write ? uw : ur);
	// Off globally, or in a handler without the option: no checks
	assign check_on = ctrl_ff[CTRL_EN_BIT] &&
		!(acc_in_handler && !ctrl_ff[CTRL_HFNMI_BIT]);
	assign viol = check_on && (any_hit ?
		(!allowed || (acc_fetch && rxn_ff[win])) :
		!(acc_priv && ctrl_ff[CTRL_PRIVDEF_BIT]));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_ff <= 1'b0;
			fault_ff <= 1'b0;
		end else begin
			done_ff <= acc_valid;
			fault_ff <= acc_valid && viol;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			faddr_ff <= FADDR_RST;
		end else if (acc_valid && viol) begin
			faddr_ff <= acc_addr;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_off_no_fault: assert property (
		!ctrl_ff[CTRL_EN_BIT] |=> !mm_fault)
		else $error("fault raised while protection off");
	chk_handler_bypass: assert property (
		acc_valid && acc_in_handler && !ctrl_ff[CTRL_HFNMI_BIT]
		|=> !mm_fault && chk_done)
		else $error("fault raised inside bypassed handler");
	chk_miss_faults: assert property (
		acc_valid && check_on && !any_hit &&
		!(acc_priv && ctrl_ff[CTRL_PRIVDEF_BIT]) |=> mm_fault)
		else $error("miss without default map did not fault");
	chk_privdef_miss: assert property (
		acc_valid && ctrl_ff[CTRL_PRIVDEF_BIT] && acc_priv && !any_hit
		|=> !mm_fault)
		else $error("privileged miss faulted with default map");
	chk_xn_fetch: assert property (
		acc_valid && check_on && any_hit && acc_fetch && rxn_ff[win]
		|=> mm_fault)
		else $error("fetch from non-executable region passed");
	chk_ro_write: assert property (
		acc_valid && check_on && any_hit && acc_write &&
		rap_ff[win] == AP_RO_RO |=> mm_fault)
		else $error("write to read-only region passed");
	chk_count_read: assert property (
		pready && !pwrite && paddr == OFF_TYPE |->
		prdata == 32'(NUM_REGIONS))
		else $error("region count readback wrong");
	chk_bad_index: assert property (
		wr && paddr == OFF_RNR && pwdata[7:0] >= 8'(NUM_REGIONS)
		|=> $stable(rnr_ff))
		else $error("out-of-range index changed selection");
	chk_disable_keeps: assert property (
		wr && paddr == OFF_RASR && !pwdata[RASR_EN_BIT]
		|=> !ren_ff[sel] && $stable(rbase_ff[sel]))
		else $error("region disable lost base address");
	chk_size_floor: assert property (
		rsize_ff[sel] >= SIZE_MIN)
		else $error("region size below minimum");
	chk_apb_ready: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("pready not a one-cycle answer");

	cov_fault: cover property (acc_valid && viol ##1 mm_fault);
	cov_privdef: cover property (acc_valid && !any_hit && acc_priv &&
		ctrl_ff[CTRL_PRIVDEF_BIT] && ctrl_ff[CTRL_EN_BIT]);
	cov_hit_ok: cover property (acc_valid && check_on && any_hit && !viol);
	cov_slverr: cover property (pslverr && pready);
endmodule // mpu_core

// ---- src/mpu_pkg.sv ----
// Constants for the memory region protection block.
// Assumes a 32-bit APB register port and a one-access-per-cycle core port.
package mpu_pkg;
	localparam int NUM_REGIONS_DEF = 8;
	localparam int ADDR_W = 8;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_TYPE = 8'h04;
	localparam logic [7:0] OFF_RNR = 8'h08;
	localparam logic [7:0] OFF_RBAR = 8'h0C;
	localparam logic [7:0] OFF_RASR = 8'h10;
	localparam logic [7:0] OFF_FADDR = 8'h14;
	// Control fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_PRIVDEF_BIT = 1;
	localparam int CTRL_HFNMI_BIT = 2;
	// Region attribute fields
	localparam int RASR_EN_BIT = 0;
	localparam int RASR_SIZE_LSB = 1;
	localparam int RASR_SRD_LSB = 8;
	localparam int RASR_AP_LSB = 24;
	localparam int RASR_XN_BIT = 28;
	localparam int BASE_LSB = 5;
	// Size code n means 2^(n+1) bytes: 4 is 32 bytes, 31 is 4 GB
	localparam logic [4:0] SIZE_MIN = 5'h04;
	localparam logic [4:0] SIZE_MAX = 5'h1F;
	localparam logic [4:0] SIZE_SUB_MIN = 5'h07;
	// Data permission codes
	localparam logic [2:0] AP_NO_NO = 3'h0;
	localparam logic [2:0] AP_RW_NO = 3'h1;
	localparam logic [2:0] AP_RW_RO = 3'h2;
	localparam logic [2:0] AP_RW_RW = 3'h3;
	localparam logic [2:0] AP_RO_NO = 3'h5;
	localparam logic [2:0] AP_RO_RO = 3'h6;
	// Reset values
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [7:0] RNR_RST = 8'h00;
	localparam logic [31:0] FADDR_RST = 32'h00000000;
endpackage

// ---- src/region_match.sv ----
// One region address matcher with sub-region holes.
// Assumes base is aligned to the size; low base bits are ignored.
`timescale 1ns/100ps
module region_match
	import mpu_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic [26:0] base,
	input wire logic [4:0] size,
	input wire logic [7:0] srd,
	input wire logic en,
	output logic hit
);
	logic [5:0] shamt;
	logic [5:0] subsh;
	logic [31:0] mask;
	logic [31:0] diff;
	logic [31:0] subv;
	logic in_reg;
	logic hole;

	// Bits above the size must match the base
	assign shamt = {1'b0, size} + 6'h01;
	assign mask = 32'hFFFFFFFF << shamt;
	assign diff = addr ^ {base, 5'h00};
	assign in_reg = ((diff & mask) == 32'h00000000);
	// Eighth of the region the address falls in
	assign subsh = {1'b0, size} - 6'h02;
	assign subv = addr >> subsh;
	// Holes only in regions of 256 bytes or more
	assign hole = (size >= SIZE_SUB_MIN) && srd[subv[2:0]];
	assign hit = en && in_reg && !hole;
endmodule // region_match

// ---- verif/core_model.sv ----
// Processor core model issuing one checked access at a time.
// Assumes the checker answers with chk_done one cycle after acc_valid.
`timescale 1ns/100ps
module core_model (
	input wire logic pclk,
	output logic acc_valid,
	output logic [31:0] acc_addr,
	output logic acc_write,
	output logic acc_fetch,
	output logic acc_priv,
	output logic acc_in_handler,
	input wire logic chk_done,
	input wire logic mm_fault
);
	initial begin
		acc_valid = 1'b0;
		acc_addr = 32'h0;
		{acc_in_handler, acc_priv, acc_fetch, acc_write} = 4'h0;
	end
	// k is {handler, privileged, fetch, write}; f returns the fault
	task automatic access(input logic [31:0] a, input logic [3:0] k,
		output logic f);
		int i;
		f = 1'bx;
		@(posedge pclk);
		acc_valid <= 1'b1;
		acc_addr <= a;
		{acc_in_handler, acc_priv, acc_fetch, acc_write} <= k;
		@(posedge pclk);
		acc_valid <= 1'b0;
		acc_addr <= ~a;
		for (i = 0; i < 4; i++) begin
			@(posedge pclk);
			if (chk_done === 1'b1) begin
				f = mm_fault;
				break;
			end
		end
	endtask
endmodule // core_model

// ---- verif/test_memory_region_protection.sv ----
// Self-checking bench: APB register tasks plus core access checks.
// Assumes mpu_core answers APB with one wait state.
`timescale 1ns/100ps
module test_memory_region_protection;
	import mpu_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic pready, pslverr, chk_done, mm_fault;
	logic [31:0] prdata, acc_addr;
	logic acc_valid, acc_write, acc_fetch, acc_priv, acc_in_handler;
	logic [31:0] d;
	logic e;
	int mismatches = 0;
	int tests_run = 0;
	logic [2:0] ap_tbl [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
	logic [5:0] uro_ok = 6'b101100;
	always #20 pclk = ~pclk;
	mpu_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .acc_valid(acc_valid), .acc_addr(acc_addr),
		.acc_write(acc_write), .acc_fetch(acc_fetch),
		.acc_priv(acc_priv), .acc_in_handler(acc_in_handler),
		.chk_done(chk_done), .mm_fault(mm_fault));
	core_model core (.pclk(pclk), .acc_valid(acc_valid),
		.acc_addr(acc_addr), .acc_write(acc_write),
		.acc_fetch(acc_fetch), .acc_priv(acc_priv),
		.acc_in_handler(acc_in_handler), .chk_done(chk_done),
		.mm_fault(mm_fault));
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 8; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				break;
			end
		end
		if (i == 8) begin
			chk(32'h0, 32'h1);
			final_report();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v, d, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, d, e);
		chk(d, x);
	endtask
	task automatic acc(input logic [31:0] a, input logic [3:0] k,
		input logic x);
		logic f;
		core.access(a, k, f);
		chk({31'h0, f}, {31'h0, x});
		if (f !== 1'b0 && f !== 1'b1) begin
			final_report();
		end
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_CTRL, 32'h0);
		rd(OFF_TYPE, 32'h8);
		rd(OFF_RNR, 32'h0);
		apb(1'b0, 8'h18, 32'h0, d, e);
		chk({31'h0, e}, 32'h1);
		acc(32'h1000, 4'h1, 1'b0);
		wr(OFF_CTRL, 32'h1);
		acc(32'h1000, 4'h4, 1'b1);
		wr(OFF_CTRL, 32'h3);
		acc(32'h1000, 4'h4, 1'b0);
		acc(32'h1000, 4'h0, 1'b1);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_RNR, 32'h0);
		wr(OFF_RBAR, 32'h1000);
		wr(OFF_RASR, 32'h12000417);
		rd(OFF_RBAR, 32'h1000);
		rd(OFF_RASR, 32'h12000417);
		wr(OFF_RNR, 32'h1);
		wr(OFF_RBAR, 32'h20);
		wr(OFF_RASR, 32'h0300FF09);
		wr(OFF_RNR, 32'h8);
		rd(OFF_RNR, 32'h1);
		wr(OFF_CTRL, 32'h1);
		acc(32'h1000, 4'h0, 1'b0);
		acc(32'h1004, 4'h1, 1'b1);
		acc(32'h1008, 4'h5, 1'b0);
		acc(32'h1000, 4'h6, 1'b1);
		acc(32'h1400, 4'h4, 1'b1);
		acc(32'h1200, 4'h4, 1'b0);
		acc(32'h20, 4'h1, 1'b0);
		acc(32'h2000, 4'h4, 1'b1);
		acc(32'h1004, 4'h9, 1'b0);
		wr(OFF_CTRL, 32'h5);
		acc(32'h1004, 4'h9, 1'b1);
		wr(OFF_CTRL, 32'h1);
		for (int i = 0; i < 6; i++) begin
			wr(OFF_RASR, 32'h0000FF09 | ({29'h0, ap_tbl[i]} << 24));
			acc(32'h20, 4'h0, ~uro_ok[i]);
		end
		acc(32'h20, 4'h5, 1'b1);
		wr(OFF_RNR, 32'h0);
		wr(OFF_RASR, 32'h12000416);
		acc(32'h1000, 4'h0, 1'b1);
		wr(OFF_RASR, 32'h12000417);
		acc(32'h1000, 4'h0, 1'b0);
		rd(OFF_RBAR, 32'h1000);
		rd(OFF_FADDR, 32'h00001000);
		final_report();
	end
endmodule // test_memory_region_protection
